//--- hdl/rtdp_pkg.sv
// constants and types for the resistance-thermometer parameter and scaling block
// assumes byte-wide parameter access and one clock for all logic
package rtdp_pkg;
	localparam int RTDP_CHANNELS = 4;
	// parameter byte offsets
	localparam logic [7:0] RTDP_OFS_LIMIT_EN   = 8'h02;
	localparam logic [7:0] RTDP_OFS_UNIT       = 8'h04;
	localparam logic [7:0] RTDP_OFS_REJECT     = 8'h05;
	localparam logic [7:0] RTDP_OFS_CH_BASE    = 8'h06;
	localparam logic [7:0] RTDP_OFS_CH_STRIDE  = 8'h06;
	localparam logic [2:0] RTDP_SUB_FN         = 3'h0;
	localparam logic [2:0] RTDP_SUB_UL_LO      = 3'h2;
	localparam logic [2:0] RTDP_SUB_UL_HI      = 3'h3;
	localparam logic [2:0] RTDP_SUB_LL_LO      = 3'h4;
	localparam logic [2:0] RTDP_SUB_LL_HI      = 3'h5;
	localparam logic [7:0] RTDP_OFS_LIMIT_FLAG = 8'h1e;
	// field masks and reset values
	localparam logic [7:0] RTDP_LIMIT_EN_MASK  = 8'h0f;
	localparam logic [7:0] RTDP_TWO_BIT_MASK   = 8'h03;
	localparam logic [7:0] RTDP_LIMIT_EN_RST   = 8'h00;
	localparam logic [7:0] RTDP_UNIT_RST       = 8'h00;
	localparam logic [7:0] RTDP_REJECT_RST     = 8'h02;
	localparam logic [7:0] RTDP_FN_RST         = 8'h50;
	localparam logic [15:0] RTDP_UL_RST        = 16'h7fff;
	localparam logic [15:0] RTDP_LL_RST        = 16'h8000;
	// codes
	localparam logic [1:0] RTDP_UNIT_C         = 2'h0;
	localparam logic [1:0] RTDP_UNIT_F         = 2'h1;
	localparam logic [1:0] RTDP_UNIT_K         = 2'h2;
	localparam logic [1:0] RTDP_REJ_60         = 2'h1;
	localparam logic [1:0] RTDP_REJ_50         = 2'h2;
	localparam logic [7:0] RTDP_FN_OFF         = 8'hff;
	localparam logic [7:0] RTDP_FN_2W          = 8'h50;
	localparam logic [7:0] RTDP_FN_3W          = 8'h58;
	localparam logic [7:0] RTDP_FN_4W          = 8'h60;
	localparam logic [7:0] RTDP_FN_SPAN        = 8'h04;
	localparam logic [2:0] RTDP_SEN_NI100      = 3'h2;
	localparam logic [2:0] RTDP_SEN_NI120      = 3'h4;
	// ranges in tenths of a degree celsius
	localparam logic signed [15:0] RTDP_PT_NOM_MAX  = 16'sh2134; // +8500
	localparam logic signed [15:0] RTDP_PT_NOM_MIN  = -16'sh07d0; // -2000
	localparam logic signed [15:0] RTDP_PT_OVR_MAX  = 16'sh2710; // +10000
	localparam logic signed [15:0] RTDP_PT_UND_MIN  = -16'sh097e; // -2430
	localparam logic signed [15:0] RTDP_NI_NOM_MAX  = 16'sh09c4; // +2500
	localparam logic signed [15:0] RTDP_NI_NOM_MIN  = -16'sh0258; // -600
	localparam logic signed [15:0] RTDP_NI_OVR_MAX  = 16'sh0b86; // +2950
	localparam logic signed [15:0] RTDP_NI_UND_MIN  = -16'sh041a; // -1050
	localparam logic signed [15:0] RTDP_N12_NOM_MAX = 16'sh0c80; // +3200
	localparam logic signed [15:0] RTDP_N12_NOM_MIN = -16'sh0320; // -800
	localparam logic signed [15:0] RTDP_N12_OVR_MAX = 16'sh0fa0; // +4000
	localparam logic signed [15:0] RTDP_N12_UND_MIN = -16'sh03e8; // -1000
	// unit conversion, tenths
	localparam logic signed [19:0] RTDP_F_MUL       = 20'sh00009;
	localparam logic signed [19:0] RTDP_F_DIV       = 20'sh00005;
	localparam logic signed [19:0] RTDP_F_OFS       = 20'sh00140; // 32.0
	localparam logic signed [19:0] RTDP_K_OFS       = 20'sh00aac; // 273.2

	typedef enum logic [1:0] {RTDP_NOM, RTDP_OVER, RTDP_UNDER} rtdp_cls_e;
	typedef enum logic [1:0] {RTDP_OFF, RTDP_PT, RTDP_NI, RTDP_NI120} rtdp_kind_e;

	typedef struct packed {
		logic        active;
		logic [1:0]  wires;
		logic [2:0]  sensor;
	} rtdp_chcfg_s;

	typedef struct packed {
		logic [1:0]  ch;
		logic [15:0] val;
	} rtdp_meas_s;

	typedef struct packed {
		logic [1:0]  ch;
		logic [15:0] val;
		rtdp_cls_e   cls;
		rtdp_kind_e  kind;
	} rtdp_res_s;
endpackage

//--- hdl/rtdp_scaling.sv
// parameter decoding, range classification, unit scaling and limit monitoring
// assumes measurements and parameter accesses come from logic on CLK_SYS
`timescale 1ns/1ps

module rtdp_scaling
	import rtdp_pkg::*;
#(
	parameter int CHANNELS = RTDP_CHANNELS
)(
	// clock and reset
	input  wire logic                 CLK_SYS,
	input  wire logic                 RST,
	input  wire logic                 CE,
	// parameter access
	input  wire logic                 PRM_WR,
	input  wire logic                 PRM_RD,
	input  wire logic [7:0]           PRM_ADDR,
	input  wire logic [7:0]           PRM_WDATA,
	output logic      [7:0]           PRM_RDATA,
	// raw measurement in tenths of a degree celsius
	input  wire logic                 MEAS_VALID,
	input  wire rtdp_meas_s           MEAS,
	// scaled result
	output logic                      RES_VALID,
	output rtdp_res_s                 RES,
	// configuration seen by the converter
	output rtdp_chcfg_s [CHANNELS-1:0] CH_CFG,
	output logic                      REJ_60HZ,
	output logic                      REJ_50HZ,
	output logic [1:0]                UNIT_SEL,
	// limit events
	output logic [CHANNELS-1:0]       LIMIT_FLAG
);

	function automatic rtdp_chcfg_s decode_fn(input logic [7:0] fn);
		rtdp_chcfg_s c;
		c = '0;
		if (fn >= RTDP_FN_2W && fn <= RTDP_FN_2W + RTDP_FN_SPAN)
		begin
			c = '{1'b1, 2'h2, 3'(fn - RTDP_FN_2W)};
		end
		else if (fn >= RTDP_FN_3W && fn <= RTDP_FN_3W + RTDP_FN_SPAN)
		begin
			c = '{1'b1, 2'h3, 3'(fn - RTDP_FN_3W)};
		end
		else if (fn >= RTDP_FN_4W && fn <= RTDP_FN_4W + RTDP_FN_SPAN)
		begin
			c = '{1'b1, 2'h0, 3'(fn - RTDP_FN_4W)};
		end
		return c;
	endfunction

	function automatic rtdp_kind_e kind_of(input rtdp_chcfg_s c);
		rtdp_kind_e k;
		k = RTDP_OFF;
		if (c.active)
		begin
			if (c.sensor < RTDP_SEN_NI100)
				k = RTDP_PT;
			else if (c.sensor < RTDP_SEN_NI120)
				k = RTDP_NI;
			else
				k = RTDP_NI120;
		end
		return k;
	endfunction

	// register file
	logic [7:0]                 lim_en_r, lim_en_nxt;
	logic [7:0]                 unit_r, unit_nxt;
	logic [7:0]                 rej_r, rej_nxt;
	logic [7:0]                 fn_r [CHANNELS];
	logic [7:0]                 fn_nxt [CHANNELS];
	logic [15:0]                ul_r [CHANNELS];
	logic [15:0]                ul_nxt [CHANNELS];
	logic [15:0]                ll_r [CHANNELS];
	logic [15:0]                ll_nxt [CHANNELS];
	logic [7:0]                 rdata_nxt;

	always_comb
	begin
		lim_en_nxt = lim_en_r;
		unit_nxt   = unit_r;
		rej_nxt    = rej_r;
		fn_nxt     = fn_r;
		ul_nxt     = ul_r;
		ll_nxt     = ll_r;
		rdata_nxt  = PRM_RDATA;
		if (PRM_WR)
		begin
			if (PRM_ADDR == RTDP_OFS_LIMIT_EN)
				lim_en_nxt = PRM_WDATA & RTDP_LIMIT_EN_MASK;
			else if (PRM_ADDR == RTDP_OFS_UNIT)
				unit_nxt = PRM_WDATA & RTDP_TWO_BIT_MASK;
			else if (PRM_ADDR == RTDP_OFS_REJECT)
				rej_nxt = PRM_WDATA & RTDP_TWO_BIT_MASK;
		end
		if (PRM_RD)
		begin
			if (PRM_ADDR == RTDP_OFS_LIMIT_EN)
				rdata_nxt = lim_en_r;
			else if (PRM_ADDR == RTDP_OFS_UNIT)
				rdata_nxt = unit_r;
			else if (PRM_ADDR == RTDP_OFS_REJECT)
				rdata_nxt = rej_r;
			else if (PRM_ADDR == RTDP_OFS_LIMIT_FLAG)
				rdata_nxt = 8'(LIMIT_FLAG);
			else
				rdata_nxt = 8'h00;
		end
		for (int i = 0; i < CHANNELS; i++)
		begin
			logic [7:0] base;
			base = 8'(RTDP_OFS_CH_BASE + RTDP_OFS_CH_STRIDE * i);
			if (PRM_WR)
			begin
				if (PRM_ADDR == base + RTDP_SUB_FN)
					fn_nxt[i] = PRM_WDATA;
				else if (PRM_ADDR == base + RTDP_SUB_UL_LO)
					ul_nxt[i][7:0] = PRM_WDATA;
				else if (PRM_ADDR == base + RTDP_SUB_UL_HI)
					ul_nxt[i][15:8] = PRM_WDATA;
				else if (PRM_ADDR == base + RTDP_SUB_LL_LO)
					ll_nxt[i][7:0] = PRM_WDATA;
				else if (PRM_ADDR == base + RTDP_SUB_LL_HI)
					ll_nxt[i][15:8] = PRM_WDATA;
			end
			if (PRM_RD)
			begin
				if (PRM_ADDR == base + RTDP_SUB_FN)
					rdata_nxt = fn_r[i];
				else if (PRM_ADDR == base + RTDP_SUB_UL_LO)
					rdata_nxt = ul_r[i][7:0];
				else if (PRM_ADDR == base + RTDP_SUB_UL_HI)
					rdata_nxt = ul_r[i][15:8];
				else if (PRM_ADDR == base + RTDP_SUB_LL_LO)
					rdata_nxt = ll_r[i][7:0];
				else if (PRM_ADDR == base + RTDP_SUB_LL_HI)
					rdata_nxt = ll_r[i][15:8];
			end
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			lim_en_r  <= RTDP_LIMIT_EN_RST;
			unit_r    <= RTDP_UNIT_RST;
			rej_r     <= RTDP_REJECT_RST;
			PRM_RDATA <= 8'h00;
			for (int i = 0; i < CHANNELS; i++)
			begin
				fn_r[i] <= RTDP_FN_RST;
				ul_r[i] <= RTDP_UL_RST;
				ll_r[i] <= RTDP_LL_RST;
			end
		end
		else if (CE)
		begin
			lim_en_r  <= lim_en_nxt;
			unit_r    <= unit_nxt;
			rej_r     <= rej_nxt;
			PRM_RDATA <= rdata_nxt;
			fn_r      <= fn_nxt;
			ul_r      <= ul_nxt;
			ll_r      <= ll_nxt;
		end
	end

	// decoded configuration and measurement path
	rtdp_chcfg_s [CHANNELS-1:0] cfg_nxt;
	logic                       res_valid_nxt;
	rtdp_res_s                  res_nxt;
	logic [CHANNELS-1:0]        flag_nxt;

	always_comb
	begin
		rtdp_chcfg_s      c;
		rtdp_kind_e       k;
		logic signed [15:0] v, nmax, nmin, omax, umin;
		logic signed [19:0] s;
		c = '0;
		k = RTDP_OFF;
		v = '0;
		nmax = RTDP_PT_NOM_MAX;
		nmin = RTDP_PT_NOM_MIN;
		omax = RTDP_PT_OVR_MAX;
		umin = RTDP_PT_UND_MIN;
		s = '0;
		for (int i = 0; i < CHANNELS; i++)
			cfg_nxt[i] = decode_fn(fn_r[i]);
		res_nxt = RES;
		res_valid_nxt = 1'b0;
		flag_nxt = LIMIT_FLAG;
		if (PRM_WR && PRM_ADDR == RTDP_OFS_LIMIT_FLAG)
			flag_nxt = LIMIT_FLAG & ~PRM_WDATA[CHANNELS-1:0];
		c = CH_CFG[MEAS.ch];
		k = kind_of(c);
		if (k == RTDP_NI)
		begin
			nmax = RTDP_NI_NOM_MAX;
			nmin = RTDP_NI_NOM_MIN;
			omax = RTDP_NI_OVR_MAX;
			umin = RTDP_NI_UND_MIN;
		end
		else if (k == RTDP_NI120)
		begin
			nmax = RTDP_N12_NOM_MAX;
			nmin = RTDP_N12_NOM_MIN;
			omax = RTDP_N12_OVR_MAX;
			umin = RTDP_N12_UND_MIN;
		end
		if (MEAS_VALID && c.active)
		begin
			v = signed'(MEAS.val);
			res_nxt.cls = RTDP_NOM;
			if (v > nmax)
			begin
				res_nxt.cls = RTDP_OVER;
				if (v > omax)
					v = omax;
			end
			else if (v < nmin)
			begin
				res_nxt.cls = RTDP_UNDER;
				if (v < umin)
					v = umin;
			end
			s = 20'(v);
			if (unit_r[1:0] == RTDP_UNIT_F)
				s = (s * RTDP_F_MUL) / RTDP_F_DIV + RTDP_F_OFS;
			else if (unit_r[1:0] == RTDP_UNIT_K)
				s = s + RTDP_K_OFS;
			res_nxt.val  = s[15:0];
			res_nxt.ch   = MEAS.ch;
			res_nxt.kind = k;
			res_valid_nxt = 1'b1;
			if (lim_en_r[MEAS.ch] && (signed'(s[15:0]) > signed'(ul_r[MEAS.ch])
				|| signed'(s[15:0]) < signed'(ll_r[MEAS.ch])))
				flag_nxt[MEAS.ch] = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			CH_CFG     <= '0;
			REJ_60HZ   <= 1'b0;
			REJ_50HZ   <= 1'b0;
			UNIT_SEL   <= RTDP_UNIT_C;
			RES_VALID  <= 1'b0;
			RES        <= '0;
			LIMIT_FLAG <= '0;
		end
		else if (CE)
		begin
			CH_CFG     <= cfg_nxt;
			REJ_60HZ   <= rej_r[1:0] == RTDP_REJ_60;
			REJ_50HZ   <= rej_r[1:0] == RTDP_REJ_50;
			UNIT_SEL   <= unit_r[1:0];
			RES_VALID  <= res_valid_nxt;
			RES        <= res_nxt;
			LIMIT_FLAG <= flag_nxt;
		end
	end

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	a_inactive_no_result: assert property (CE && MEAS_VALID && !CH_CFG[MEAS.ch].active
		|=> !RES_VALID) else $error("result from inactive channel");
	a_flag_needs_enable: assert property (CE && !lim_en_r[MEAS.ch] && !LIMIT_FLAG[MEAS.ch]
		|=> !LIMIT_FLAG[$past(MEAS.ch)]) else $error("flag set while disabled");
	a_unit_follows: assert property ((CE && $stable(unit_r)) [*2] |-> UNIT_SEL == unit_r[1:0])
		else $error("unit select mismatch");
	a_reject_decode: assert property (CE |=> REJ_60HZ == ($past(rej_r[1:0]) == RTDP_REJ_60)
		&& REJ_50HZ == ($past(rej_r[1:0]) == RTDP_REJ_50)) else $error("reject decode");
	a_pt_range: assert property (RES_VALID && RES.kind == RTDP_PT && $past(unit_r[1:0]) == RTDP_UNIT_C
		|-> signed'(RES.val) <= RTDP_PT_OVR_MAX && signed'(RES.val) >= RTDP_PT_UND_MIN
		&& (RES.cls != RTDP_NOM || signed'(RES.val) <= RTDP_PT_NOM_MAX))
		else $error("platinum range");
	a_ni_range: assert property (RES_VALID && RES.kind == RTDP_NI && $past(unit_r[1:0]) == RTDP_UNIT_C
		|-> signed'(RES.val) <= RTDP_NI_OVR_MAX && signed'(RES.val) >= RTDP_NI_UND_MIN)
		else $error("nickel range");
	a_ni120_range: assert property (RES_VALID && RES.kind == RTDP_NI120
		&& $past(unit_r[1:0]) == RTDP_UNIT_C |-> signed'(RES.val) <= RTDP_N12_OVR_MAX
		&& signed'(RES.val) >= RTDP_N12_UND_MIN) else $error("nickel 120 range");
	a_limit_cause: assert property ($rose(LIMIT_FLAG[0]) |-> $past(lim_en_r[0])
		&& RES_VALID && RES.ch == 2'h0) else $error("limit flag without cause");
	a_reserved_zero: assert property (lim_en_r[7:4] == 4'h0 && unit_r[7:2] == 6'h00
		&& rej_r[7:2] == 6'h00) else $error("reserved bits stored");

	c_pt_over: cover property (RES_VALID && RES.kind == RTDP_PT && RES.cls == RTDP_OVER);
	c_fahrenheit: cover property (RES_VALID && UNIT_SEL == RTDP_UNIT_F);
	c_limit_hit: cover property ($rose(LIMIT_FLAG[0]));
	c_inactive_drop: cover property (CE && MEAS_VALID && !CH_CFG[MEAS.ch].active);

endmodule // rtdp_scaling

//--- verif/rtdp_host_model.sv
// host side of the parameter bus: byte writes and byte reads
// assumes the block samples the bus on the rising clock edge
`timescale 1ns/1ps
module rtdp_host_model (
	// clock
	input  wire logic       clk,
	// parameter bus
	output logic            prm_wr,
	output logic            prm_rd,
	output logic [7:0]      prm_addr,
	output logic [7:0]      prm_wdata,
	input  wire logic [7:0] prm_rdata
);
	initial
	begin
		prm_wr    = 1'b0;
		prm_rd    = 1'b0;
		prm_addr  = 8'h00;
		prm_wdata = 8'h00;
	end

	// one byte write, released bus shows inverted values
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		prm_wr    <= 1'b1;
		prm_addr  <= a;
		prm_wdata <= d;
		@(posedge clk);
		prm_wr    <= 1'b0;
		prm_addr  <= ~a;
		prm_wdata <= ~d;
	endtask

	// one byte read, data taken one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		prm_rd   <= 1'b1;
		prm_addr <= a;
		@(posedge clk);
		prm_rd   <= 1'b0;
		prm_addr <= ~a;
		#1;
		d = prm_rdata;
	endtask
endmodule // rtdp_host_model

//--- verif/rtdp_scaling_tb.sv
// self-checking bench for the parameter decoding and scaling block
// assumes the host model drives the parameter bus
`timescale 1ns/1ps
module rtdp_scaling_tb;
	import rtdp_pkg::*;
	logic              clk_sys = 1'b0;
	logic              rst = 1'b1;
	logic              ce = 1'b1;
	logic              prm_wr, prm_rd;
	logic [7:0]        prm_addr, prm_wdata, prm_rdata;
	logic              meas_valid = 1'b0;
	rtdp_meas_s        meas = '0;
	logic              res_valid;
	rtdp_res_s         res;
	rtdp_chcfg_s [3:0] ch_cfg;
	logic              rej_60hz, rej_50hz;
	logic [1:0]        unit_sel;
	logic [3:0]        limit_flag;
	int                err_count = 0;
	int                check_count = 0;
	logic [15:0]       unit_exp [3] = '{16'd1000, 16'd2120, 16'd3732};

	always #12.5 clk_sys = ~clk_sys;

	rtdp_host_model rtdp_host_model_i (.clk(clk_sys), .prm_wr(prm_wr), .prm_rd(prm_rd),
		.prm_addr(prm_addr), .prm_wdata(prm_wdata), .prm_rdata(prm_rdata));

	rtdp_scaling rtdp_scaling_i (.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .PRM_WR(prm_wr),
		.PRM_RD(prm_rd), .PRM_ADDR(prm_addr), .PRM_WDATA(prm_wdata), .PRM_RDATA(prm_rdata),
		.MEAS_VALID(meas_valid), .MEAS(meas), .RES_VALID(res_valid), .RES(res),
		.CH_CFG(ch_cfg), .REJ_60HZ(rej_60hz), .REJ_50HZ(rej_50hz), .UNIT_SEL(unit_sel),
		.LIMIT_FLAG(limit_flag));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rtdp_host_model_i.rd(a, v);
		chk(32'(v), 32'(exp));
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		rtdp_host_model_i.wr(a, v);
		@(posedge clk_sys);
		#1;
	endtask

	// measurement, result checked one cycle after the strobe edge
	task automatic mchk(input logic [1:0] ch, input logic [15:0] v, input logic vld,
		input rtdp_cls_e cls, input rtdp_kind_e kind, input logic [15:0] exp);
		@(posedge clk_sys);
		meas_valid <= 1'b1;
		meas       <= '{ch: ch, val: v};
		@(posedge clk_sys);
		meas_valid <= 1'b0;
		#1;
		chk(32'(res_valid), 32'(vld));
		if (vld)
			chk({10'h000, res.ch, res.cls, res.kind, res.val}, {10'h000, ch, cls, kind, exp});
	endtask

	// channel 1 function code, decoded config, clamping at both ends
	task automatic run_fn(input logic [7:0] code, input rtdp_chcfg_s cfg, input rtdp_kind_e kind,
		input logic [15:0] nmax, input logic [15:0] omax, input logic [15:0] umin);
		wr(8'h0c, code);
		chk(32'(ch_cfg[1]), 32'(cfg));
		mchk(2'h1, nmax, cfg.active, RTDP_NOM, kind, nmax);
		mchk(2'h1, 16'h7000, cfg.active, RTDP_OVER, kind, omax);
		mchk(2'h1, 16'h9000, cfg.active, RTDP_UNDER, kind, umin);
	endtask

	task automatic finish_test;
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		finish_test;
	end

	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rchk(RTDP_OFS_LIMIT_EN, 8'h00);
		chk(32'(ch_cfg), 32'({4{6'b1_10_000}}));
		rchk(RTDP_OFS_UNIT, 8'h00);
		rchk(RTDP_OFS_REJECT, 8'h02);
		rchk(8'h06, 8'h50);
		rchk(8'h08, 8'hff);
		rchk(8'h09, 8'h7f);
		rchk(8'h0a, 8'h00);
		rchk(8'h0b, 8'h80);
		rchk(8'h07, 8'h00);
		rchk(8'h30, 8'h00);
		wr(RTDP_OFS_LIMIT_EN, 8'hf0);
		rchk(RTDP_OFS_LIMIT_EN, 8'h00);
		wr(RTDP_OFS_UNIT, 8'hfc);
		rchk(RTDP_OFS_UNIT, 8'h00);
		wr(RTDP_OFS_REJECT, 8'h01);
		chk({rej_60hz, rej_50hz}, 2'b10);
		wr(RTDP_OFS_REJECT, 8'hfe);
		chk({rej_60hz, rej_50hz}, 2'b01);
		rchk(RTDP_OFS_REJECT, 8'h02);
		for (int i = 0; i < 3; i++)
		begin
			wr(RTDP_OFS_UNIT, 8'(i));
			chk(32'(unit_sel), i);
			mchk(2'h0, 16'd1000, 1'b1, RTDP_NOM, RTDP_PT, unit_exp[i]);
		end
		wr(RTDP_OFS_UNIT, RTDP_UNIT_C);
		// clock enable low: a write strobe must leave the unit register untouched
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(RTDP_OFS_UNIT, 8'(RTDP_UNIT_K));
		@(posedge clk_sys);
		ce <= 1'b1;
		rchk(RTDP_OFS_UNIT, 8'h00);
		chk(32'(unit_sel), 32'(RTDP_UNIT_C));
		run_fn(8'h50, 6'b1_10_000, RTDP_PT, RTDP_PT_NOM_MAX, RTDP_PT_OVR_MAX, RTDP_PT_UND_MIN);
		run_fn(8'h5a, 6'b1_11_010, RTDP_NI, RTDP_NI_NOM_MAX, RTDP_NI_OVR_MAX, RTDP_NI_UND_MIN);
		run_fn(8'h5c, 6'b1_11_100, RTDP_NI120, RTDP_N12_NOM_MAX, RTDP_N12_OVR_MAX, RTDP_N12_UND_MIN);
		run_fn(8'h61, 6'b1_00_001, RTDP_PT, RTDP_PT_NOM_MIN, RTDP_PT_OVR_MAX, RTDP_PT_UND_MIN);
		run_fn(8'h53, 6'b1_10_011, RTDP_NI, RTDP_NI_NOM_MIN, RTDP_NI_OVR_MAX, RTDP_NI_UND_MIN);
		wr(8'h0c, RTDP_FN_OFF);
		chk(32'(ch_cfg[1].active), 0);
		mchk(2'h1, 16'd100, 1'b0, RTDP_NOM, RTDP_OFF, 16'h0000);
		wr(8'h08, 8'h64);
		wr(8'h09, 8'h00);
		wr(RTDP_OFS_LIMIT_EN, 8'h01);
		mchk(2'h0, 16'd200, 1'b1, RTDP_NOM, RTDP_PT, 16'd200);
		chk(32'(limit_flag), 32'h1);
		wr(RTDP_OFS_LIMIT_FLAG, 8'h01);
		chk(32'(limit_flag), 32'h0);
		wr(8'h0a, 8'h00);
		wr(8'h0b, 8'h00);
		mchk(2'h0, 16'hffce, 1'b1, RTDP_NOM, RTDP_PT, 16'hffce);
		rchk(RTDP_OFS_LIMIT_FLAG, 8'h01);
		wr(RTDP_OFS_LIMIT_FLAG, 8'h01);
		wr(RTDP_OFS_LIMIT_EN, 8'h00);
		mchk(2'h0, 16'd200, 1'b1, RTDP_NOM, RTDP_PT, 16'd200);
		chk(32'(limit_flag), 32'h0);
		finish_test;
	end
endmodule // rtdp_scaling_tb
